// ==== bench/pnfi_flash_model.sv ====
// Purpose: Behavioural flash with command decode and busy timing
// Assumes: Pins come from host flip-flops on the same clock
// Notes:   Sixteen locations only; unlock addresses are not checked
module pnfi_flash_model
  import pnfi_pkg::*;
#(
  parameter int PROG_CYC = 6,
  parameter int ERA_CYC  = 150
) (
  input  wire logic        clk_sys_in,
  input  wire logic [18:0] a_in,
  input  wire logic [15:0] d_in,
  input  wire logic [15:0] doe_n_in,
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        by_n_in,
  input  wire logic        rs_n_in,
  output logic      [15:0] q_out,
  output logic             rb_n_out
);
  logic [15:0] mem [16];
  logic [15:0] rd;
  logic [3:0]  idx;
  logic [7:0]  c;
  logic [2:0]  step;
  logic        byp, susp, era, chip, esec, tog, busy;
  int          cnt;
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    {tog, step, byp, susp, era, chip, esec} = '0;
  end
  // Byte mode takes the address LSB from the top data pin
  assign idx = by_n_in ? a_in[3:0] : {a_in[2:0], d_in[15]};
  assign c = d_in[7:0];
  assign busy = cnt != 0 && !susp;
  assign rb_n_out = !busy;
  assign rd = busy ? {8'h00, ~mem[idx][7], tog, 6'h00} :
              by_n_in ? mem[idx] : {8'h00, mem[idx][7:0]};
  // Released lanes show a changing pattern, never the last value
  always_comb begin
    for (int b = 0; b < 16; b++) begin
      if (!doe_n_in[b]) q_out[b] = d_in[b];
      else if (!ce_n_in && !oe_n_in && (by_n_in || b < 8)) q_out[b] = rd[b];
      else q_out[b] = tog ^ b[0];
    end
  end
  // Command decode on each write strobe; reset aborts everything
  always @(posedge clk_sys_in) begin
    tog <= ~tog;
    if (!rs_n_in) begin
      cnt <= 0;
      step <= 3'd0;
      byp <= 1'b0;
      susp <= 1'b0;
      era <= 1'b0;
    end else begin
      if (busy) cnt <= cnt - 1;
      if (busy && cnt == 1 && era) begin
        foreach (mem[i]) if (chip || i[3] == esec) mem[i] <= 16'hFFFF;
        era <= 1'b0;
      end
      if (!ce_n_in && !we_n_in) begin
        step <= 3'd0;
        if (busy) begin
          if (era && c == CMD_SUSPEND[7:0]) susp <= 1'b1;
        end else if (susp && c == CMD_RESUME[7:0]) susp <= 1'b0;
        else case (step)
          3'd0: if (c == CMD_UNLK1[7:0]) step <= 3'd1;
            else if (byp && c == CMD_PROG[7:0]) step <= 3'd3;
            else if (byp && c == CMD_BYP_X1[7:0]) step <= 3'd7;
          3'd1, 3'd5: if (c == CMD_UNLK2[7:0]) step <= step + 3'd1;
          3'd2: if (c == CMD_PROG[7:0]) step <= 3'd3;
            else if (c == CMD_ERA_SET[7:0]) step <= 3'd4;
            else if (c == CMD_BYPASS[7:0]) byp <= 1'b1;
          3'd3: begin
            mem[idx] <= by_n_in ? d_in : {8'hFF, c};
            cnt <= PROG_CYC;
          end
          3'd4: if (c == CMD_UNLK1[7:0]) step <= 3'd5;
          3'd6: if (c == CMD_ERA_SEC[7:0] || c == CMD_ERA_CHP[7:0]) begin
            era <= 1'b1;
            chip <= c == CMD_ERA_CHP[7:0];
            esec <= idx[3];
            cnt <= ERA_CYC;
          end
          default: byp <= 1'b0;
        endcase
      end
    end
  end
endmodule : pnfi_flash_model

// ==== bench/pnfi_properties.sv ====
// Purpose: Concurrent checks on the flash controller ports
// Assumes: One clock domain, checker bound into pnfi_top
// Notes:   Pin figures follow the controller's cycle timing
module pnfi_chk (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic        avs_waitrequest_out,
  input wire logic [18:0] flash_addr_out,
  input wire logic [15:0] flash_dq_out,
  input wire logic [15:0] flash_dq_oe_n_out,
  input wire logic        flash_ce_n_out,
  input wire logic        flash_oe_n_out,
  input wire logic        flash_we_n_out,
  input wire logic        flash_byte_n_out,
  input wire logic        flash_reset_n_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Strobe levels the flash decodes as a write or a read
  write_strobe_a: assert property (!flash_we_n_out |->
    !flash_ce_n_out && flash_oe_n_out) else $error("bad write strobe");
  read_release_a: assert property (!flash_oe_n_out |->
    !flash_ce_n_out && flash_we_n_out && flash_dq_oe_n_out[14:0] == 15'h7FFF)
    else $error("bad read cycle");
  // Byte mode lanes: upper lanes free, top pin is the address LSB
  byte_lanes_a: assert property (!flash_byte_n_out && !flash_ce_n_out |->
    flash_dq_oe_n_out[14:8] == 7'h7F) else $error("upper lanes driven");
  byte_lsb_a: assert property (!flash_byte_n_out && !flash_ce_n_out |->
    !flash_dq_oe_n_out[15]) else $error("address LSB not driven");
  word_path_a: assert property (flash_byte_n_out && !flash_we_n_out |->
    flash_dq_oe_n_out == 16'h0000) else $error("word write not full width");
  // Address and data held round the write pulse so the flash latches them
  write_pulse_a: assert property ($fell(flash_we_n_out) |->
    $stable(flash_addr_out) ##1 flash_we_n_out && $stable(flash_addr_out)
    && $stable(flash_dq_out) ##1 flash_ce_n_out) else $error("bad pulse");
  reset_pulse_a: assert property ($fell(flash_reset_n_out) |->
    (!flash_reset_n_out && flash_ce_n_out) [*5] ##1 flash_reset_n_out)
    else $error("bad reset pulse");
  wait_state_a: assert property ($rose(avs_read_in || avs_write_in) |->
    avs_waitrequest_out ##1 !avs_waitrequest_out) else $error("bad wait");
  // Main scenarios reached
  cover property (!flash_byte_n_out && !flash_we_n_out);
  cover property ($rose(flash_reset_n_out));
  cover property (flash_byte_n_out && !flash_oe_n_out);
endmodule : pnfi_chk

bind pnfi_top pnfi_chk i_chk (.clk_sys_in, .rst_n_in, .avs_read_in,
  .avs_write_in, .avs_waitrequest_out, .flash_addr_out, .flash_dq_out,
  .flash_dq_oe_n_out, .flash_ce_n_out, .flash_oe_n_out, .flash_we_n_out,
  .flash_byte_n_out, .flash_reset_n_out);

// ==== bench/testbench.sv ====
// Purpose: Register-level test of the flash controller with a flash model
// Assumes: Model erase time far above the shortened busy timeout
// Notes:   Pin timing is judged by the bound checker
module testbench
  import pnfi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_in, rst_n_in, avs_read_in, avs_write_in;
  logic        avs_waitrequest_out, rbn, ce_n, oe_n, we_n, byte_n, rst_n;
  logic [4:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rdq;
  logic [15:0] dq_in, dq_out, dq_oe_n;
  logic [18:0] addr;
  int          n_errors = 0;
  int          compares = 0;
  pnfi_top #(.TIMEOUT_CYC(50)) i_dut (.clk_sys_in, .rst_n_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_readdata_out, .avs_waitrequest_out, .flash_dq_in(dq_in),
    .flash_ready_busy_n_in(rbn), .flash_addr_out(addr),
    .flash_dq_out(dq_out), .flash_dq_oe_n_out(dq_oe_n),
    .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n), .flash_we_n_out(we_n),
    .flash_byte_n_out(byte_n), .flash_reset_n_out(rst_n));
  pnfi_flash_model i_flash (.clk_sys_in, .a_in(addr), .d_in(dq_out),
    .doe_n_in(dq_oe_n), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
    .by_n_in(byte_n), .rs_n_in(rst_n), .q_out(dq_in), .rb_n_out(rbn));
  task automatic stop_test;
    if (n_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [4:0] a, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value reg %h expected %h seen %h", a, e, g);
    end
  endtask : chk
  // One access; held until waitrequest is low at a rising edge
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i = 0;
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    do begin
      @(posedge clk_sys_in);
      i++;
    end while (avs_waitrequest_out !== 1'b0 && i < 20);
    if (avs_waitrequest_out !== 1'b0) n_errors++;
    if (avs_waitrequest_out !== 1'b0) stop_test;
    rdq = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : av
  task automatic rchk(input logic [4:0] a, input logic [31:0] e, m);
    av(1'b0, a, 32'h0000_0000);
    chk(a, e, rdq & m);
  endtask : rchk
  task automatic go(input logic [3:0] op, input logic [19:0] a,
                    input logic [15:0] d);
    av(1'b1, REG_ADDR, {12'h000, a});
    av(1'b1, REG_WDATA, {16'h0000, d});
    av(1'b1, REG_CMD, {28'h000_0000, op});
  endtask : go
  // Bounded poll of one status bit
  task automatic wt(input int b, input logic v);
    int i;
    for (i = 0; i < 300 && rdq[b] !== v; i++) av(1'b0, REG_STATUS, 32'h0);
    if (rdq[b] !== v) n_errors++;
    if (rdq[b] !== v) stop_test;
  endtask : wt
  task automatic run(input logic [3:0] op, input logic [19:0] a,
                     input logic [15:0] d);
    go(op, a, d);
    rdq = 32'hFFFF_FFFF;
    wt(ST_BUSY, 1'b0);
  endtask : run
  task automatic rdf(input logic [19:0] a, input logic [31:0] e);
    run(OP_READ, a, 16'h0000);
    rchk(REG_RDATA, e, 32'h0000_FFFF);
  endtask : rdf
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // Main sequence
  initial begin
    rst_n_in = 1'b0;
    {avs_read_in, avs_write_in, avs_address_in} = '0;
    avs_writedata_in = 32'h0000_0000;
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rchk(REG_CFG, 32'h0000_0001, 32'hFFFF_FFFF);
    rchk(5'h18, 32'h0000_0000, 32'hFFFF_FFFF);
    go(OP_PROGRAM, 20'h0_0003, 16'h1234);
    av(1'b1, REG_CMD, 32'h0000_0001);
    rchk(REG_STATUS, 32'h0000_0009, 32'h0000_0009);
    rdq = 32'hFFFF_FFFF;
    wt(ST_BUSY, 1'b0);
    rchk(REG_STATUS, 32'h0000_0002, 32'h0000_0007);
    run(OP_PROGRAM, 20'h0_0009, 16'h5678);
    run(OP_BYP_ENT, 20'h0_0000, 16'h0000);
    rchk(REG_STATUS, 32'h0000_0020, 32'h0000_0020);
    run(OP_BYP_PROG, 20'h0_0005, 16'hABCD);
    run(OP_BYP_EXIT, 20'h0_0000, 16'h0000);
    go(OP_BYP_PROG, 20'h0_0005, 16'h0000);
    rchk(REG_STATUS, 32'h0000_0008, 32'h0000_0028);
    run(OP_RAW_WR, 20'h0_0003, 16'h0000);
    rdf(20'h0_0003, 32'h0000_1234);
    rdf(20'h0_0005, 32'h0000_ABCD);
    run(OP_SEC_ERA, 20'h0_0000, 16'h0000);
    rchk(REG_STATUS, 32'h0000_0006, 32'h0000_0016);
    run(OP_SUSPEND, 20'h0_0000, 16'h0000);
    rchk(REG_STATUS, 32'h0000_0050, 32'h0000_0050);
    rdf(20'h0_0009, 32'h0000_5678);
    run(OP_RESUME, 20'h0_0000, 16'h0000);
    wt(ST_RDY_PIN, 1'b1);
    rdf(20'h0_0003, 32'h0000_FFFF);
    rdf(20'h0_0009, 32'h0000_5678);
    av(1'b1, REG_CFG, 32'h0000_0000);
    run(OP_PROGRAM, 20'h0_0007, 16'h005A);
    rdf(20'h0_0007, 32'h0000_005A);
    av(1'b1, REG_CFG, 32'h0000_0001);
    run(OP_CHIP_ERA, 20'h0_0000, 16'h0000);
    run(OP_HW_RESET, 20'h0_0000, 16'h0000);
    rchk(REG_STATUS, 32'h0000_0010, 32'h0000_0070);
    rdf(20'h0_0009, 32'h0000_5678);
    stop_test;
  end
endmodule : testbench

// ==== src/pnfi_cyc_if.sv ====
// Purpose: One flash bus cycle request between sequencer and pin engine
// Assumes: req is a one-cycle pulse, done a one-cycle pulse
// Notes:   addr is a byte address in byte mode, a word address otherwise
interface pnfi_cyc_if;
  logic        req;
  logic        wr;
  logic        word_mode;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;

  modport seq (output req, wr, word_mode, addr, wdata, input done, rdata);
  modport eng (input req, wr, word_mode, addr, wdata, output done, rdata);
endinterface : pnfi_cyc_if

// ==== src/pnfi_cycle.sv ====
// Purpose: Drives one read or write cycle on the flash pins
// Assumes: Requests only arrive while the engine is idle
// Notes:   All pins come from flip-flops, so no glitches reach the flash
module pnfi_cycle
  import pnfi_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  pnfi_cyc_if.eng          cyc,
  input  wire logic [15:0] flash_dq_in,
  output logic      [18:0] flash_addr_out,
  output logic      [15:0] flash_dq_out,
  output logic      [15:0] flash_dq_oe_n_out,
  output logic             flash_ce_n_out,
  output logic             flash_oe_n_out,
  output logic             flash_we_n_out
);

  pnfi_cst_t   state_reg;
  logic [7:0]  cnt_reg;
  logic        wr_reg;
  logic        word_reg;
  logic        done_reg;
  logic [15:0] rdata_reg;
  logic        last;

  assign last      = (state_reg == C_SET) ? (cnt_reg == 8'(TACC_CYC - 1)) :
                     (state_reg == C_STB) ? (cnt_reg == 8'(TWP_CYC - 1)) :
                     (cnt_reg == 8'(TWPH_CYC - 1));
  assign cyc.done  = done_reg;
  assign cyc.rdata = rdata_reg;

  // Cycle state and phase counter
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_reg <= C_IDLE;
      cnt_reg   <= 8'h00;
      wr_reg    <= 1'b0;
      word_reg  <= 1'b1;
    end else begin
      cnt_reg <= last ? 8'h00 : cnt_reg + 8'h01;
      case (state_reg)
        C_IDLE: begin
          cnt_reg <= 8'h00;
          if (cyc.req) begin
            state_reg <= C_SET;
            wr_reg    <= cyc.wr;
            word_reg  <= cyc.word_mode;
          end
        end
        C_SET: begin
          if (wr_reg) begin
            state_reg <= C_STB; // Address and data settle one cycle
            cnt_reg   <= 8'h00;
          end else if (last) begin
            state_reg <= C_IDLE;
          end
        end
        C_STB:   if (last) state_reg <= C_HLD;
        C_HLD:   if (last) state_reg <= C_IDLE;
        default: state_reg <= C_IDLE;
      endcase
    end
  end

  // Pin drive; idle leaves chip select high and the bus released
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      flash_addr_out    <= 19'h0_0000;
      flash_dq_out      <= 16'h0000;
      flash_dq_oe_n_out <= 16'hFFFF;
      flash_ce_n_out    <= 1'b1;
      flash_oe_n_out    <= 1'b1;
      flash_we_n_out    <= 1'b1;
    end else if (state_reg == C_IDLE && cyc.req) begin
      flash_ce_n_out <= 1'b0;
      flash_oe_n_out <= cyc.wr;
      flash_we_n_out <= 1'b1;
      if (cyc.word_mode) begin
        flash_addr_out    <= cyc.addr[18:0];
        flash_dq_out      <= cyc.wdata;
        flash_dq_oe_n_out <= {16{~cyc.wr}};
      end else begin
        flash_addr_out    <= cyc.addr[19:1];
        flash_dq_out      <= {cyc.addr[0], 7'h00, cyc.wdata[7:0]};
        flash_dq_oe_n_out <= {1'b0, 7'h7F, {8{~cyc.wr}}};
      end
    end else if (state_reg == C_SET && wr_reg) begin
      flash_we_n_out <= 1'b0;
    end else if (state_reg == C_STB && last) begin
      flash_we_n_out <= 1'b1;
    end else if ((state_reg == C_HLD && last) ||
                 (state_reg == C_SET && !wr_reg && last)) begin
      flash_ce_n_out    <= 1'b1;
      flash_oe_n_out    <= 1'b1;
      flash_dq_oe_n_out <= 16'hFFFF;
    end
  end

  // Completion pulse at the end of the cycle, read capture at the end of access time
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      done_reg  <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      done_reg <= last && ((state_reg == C_HLD) ||
                           (state_reg == C_SET && !wr_reg));
      if (state_reg == C_SET && !wr_reg && last) begin
        rdata_reg <= word_reg ? flash_dq_in : {8'h00, flash_dq_in[7:0]};
      end
    end
  end

endmodule : pnfi_cycle

// ==== src/pnfi_pkg.sv ====
// Purpose: Shared constants and types of the parallel NOR flash controller
// Assumes: 10 MHz system clock, flash pins synchronous to that clock
// Notes:   Command codes and unlock addresses are plain defaults
package pnfi_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] REG_CMD    = 5'h00;
  localparam logic [4:0] REG_ADDR   = 5'h04;
  localparam logic [4:0] REG_WDATA  = 5'h08;
  localparam logic [4:0] REG_RDATA  = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_CFG    = 5'h14;

  // Status field positions and config reset value
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_TMO     = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_RDY_PIN = 4;
  localparam int ST_BYPASS  = 5;
  localparam int ST_SUSP    = 6;
  localparam int CFG_WORD   = 0;
  localparam logic CFG_WORD_RST = 1'b1;

  // Operations software may start
  localparam logic [3:0] OP_READ     = 4'h0;
  localparam logic [3:0] OP_PROGRAM  = 4'h1;
  localparam logic [3:0] OP_BYP_ENT  = 4'h2;
  localparam logic [3:0] OP_BYP_PROG = 4'h3;
  localparam logic [3:0] OP_BYP_EXIT = 4'h4;
  localparam logic [3:0] OP_SEC_ERA  = 4'h5;
  localparam logic [3:0] OP_CHIP_ERA = 4'h6;
  localparam logic [3:0] OP_SUSPEND  = 4'h7;
  localparam logic [3:0] OP_RESUME   = 4'h8;
  localparam logic [3:0] OP_HW_RESET = 4'h9;
  localparam logic [3:0] OP_RAW_WR   = 4'hA;

  // Bus command codes and unlock locations
  localparam logic [15:0] CMD_UNLK1   = 16'h00AA;
  localparam logic [15:0] CMD_UNLK2   = 16'h0055;
  localparam logic [15:0] CMD_PROG    = 16'h00A0;
  localparam logic [15:0] CMD_BYPASS  = 16'h0020;
  localparam logic [15:0] CMD_BYP_X1  = 16'h0090;
  localparam logic [15:0] CMD_BYP_X2  = 16'h0000;
  localparam logic [15:0] CMD_ERA_SET = 16'h0080;
  localparam logic [15:0] CMD_ERA_SEC = 16'h0030;
  localparam logic [15:0] CMD_ERA_CHP = 16'h0010;
  localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
  localparam logic [15:0] CMD_RESUME  = 16'h0030;
  localparam logic [19:0] UA1_WORD    = 20'h0_0555;
  localparam logic [19:0] UA2_WORD    = 20'h0_02AA;
  localparam logic [19:0] UA1_BYTE    = 20'h0_0AAA;
  localparam logic [19:0] UA2_BYTE    = 20'h0_0555;

  // Timing in ns (busy timeout in ms) and derived cycle counts, least times round up
  localparam int CLK_MHZ  = 10;
  localparam int TACC_NS  = 70;
  localparam int TWP_NS   = 35;
  localparam int TWPH_NS  = 30;
  localparam int TRP_NS   = 500;
  localparam int TRH_NS   = 50;
  localparam int TBUSY_NS = 90;
  localparam int TACC_CYC  = (TACC_NS * CLK_MHZ + 999) / 1000;
  localparam int TWP_CYC   = (TWP_NS * CLK_MHZ + 999) / 1000;
  localparam int TWPH_CYC  = (TWPH_NS * CLK_MHZ + 999) / 1000;
  localparam int TRP_CYC   = (TRP_NS * CLK_MHZ + 999) / 1000;
  localparam int TRH_CYC   = (TRH_NS * CLK_MHZ + 999) / 1000;
  localparam int TBUSY_CYC = (TBUSY_NS * CLK_MHZ + 999) / 1000;
  localparam int BUSY_TMO_MS  = 20000;
  localparam int BUSY_TMO_CYC = BUSY_TMO_MS * CLK_MHZ * 1000;

  // Pin cycle engine states
  typedef enum logic [3:0] {
    C_IDLE = 4'b0001,
    C_SET  = 4'b0010,
    C_STB  = 4'b0100,
    C_HLD  = 4'b1000
  } pnfi_cst_t;

  // Sequencer states
  typedef enum logic [6:0] {
    S_IDLE  = 7'b000_0001,
    S_ISSUE = 7'b000_0010,
    S_WAIT  = 7'b000_0100,
    S_BDLY  = 7'b000_1000,
    S_BUSY  = 7'b001_0000,
    S_RSTLO = 7'b010_0000,
    S_RSTHI = 7'b100_0000
  } pnfi_sst_t;

endpackage : pnfi_pkg

// ==== src/pnfi_top.sv ====
// Purpose: Host controller for a parallel NOR flash, Avalon-MM slave
// Assumes: Flash outputs are synchronous to clk_sys_in
// Notes:   One operation at a time; software polls the status register
//
// Summary of operation
// - In byte mode the top data pin carries the byte address LSB.
// - Writes use write enable low, chip select low, output enable high.
// - Output enable is low for reads and high for writes.
// - Normal program uses a four-write sequence, then runs internally.
// - In bypass mode a program takes only two write cycles.
// - Completion is seen on status bits or on ready/busy.
// - Reads drive chip select and output enable low, write enable high.
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
module pnfi_top
  import pnfi_pkg::*;
#(
  parameter int TIMEOUT_CYC = BUSY_TMO_CYC
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic [15:0] flash_dq_in,
  input  wire logic        flash_ready_busy_n_in,
  output logic      [18:0] flash_addr_out,
  output logic      [15:0] flash_dq_out,
  output logic      [15:0] flash_dq_oe_n_out,
  output logic             flash_ce_n_out,
  output logic             flash_oe_n_out,
  output logic             flash_we_n_out,
  output logic             flash_byte_n_out,
  output logic             flash_reset_n_out
);

  pnfi_cyc_if cyc ();

  pnfi_sst_t   state_reg;
  logic        acc_reg;
  logic [31:0] rd_reg;
  logic [3:0]  op_reg;
  logic [19:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic        word_reg;
  logic        done_reg;
  logic        tmo_reg;
  logic        refused_reg;
  logic        bypass_reg;
  logic        susp_reg;
  logic [2:0]  step_reg;
  logic [31:0] cnt_reg;
  logic        start;
  logic [3:0]  new_op;
  logic        refuse;
  logic        needs_busy;
  logic        st_last;
  logic [19:0] ua1;
  logic [19:0] ua2;

  // Avalon slave: one wait state, so decode and read data are registered
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !acc_reg;
  assign avs_readdata_out    = rd_reg;
  assign start  = avs_write_in && acc_reg && avs_address_in == REG_CMD;
  assign new_op = avs_writedata_in[3:0];

  // Host keeps off busy flash and unknown orders; reads stay legal
  assign refuse = (state_reg != S_IDLE) || (new_op > OP_RAW_WR) ||
                  (!flash_ready_busy_n_in && new_op != OP_SUSPEND &&
                   new_op != OP_READ && new_op != OP_HW_RESET) ||
                  (new_op == OP_BYP_PROG && !bypass_reg);
  assign needs_busy = op_reg == OP_PROGRAM || op_reg == OP_BYP_PROG ||
                      op_reg == OP_SEC_ERA || op_reg == OP_CHIP_ERA ||
                      op_reg == OP_SUSPEND || op_reg == OP_RESUME;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      acc_reg <= 1'b0;
      rd_reg  <= 32'h0000_0000;
    end else begin
      acc_reg <= (avs_read_in || avs_write_in) && !acc_reg;
      rd_reg  <= 32'h0000_0000; // Unmapped offsets read as zero
      if (avs_read_in && !acc_reg) begin
        case (avs_address_in)
          REG_CMD:    rd_reg <= {28'h000_0000, op_reg};
          REG_ADDR:   rd_reg <= {12'h000, addr_reg};
          REG_WDATA:  rd_reg <= {16'h0000, wdata_reg};
          REG_RDATA:  rd_reg <= {16'h0000, rdata_reg};
          REG_STATUS: rd_reg <= {25'h000_0000, susp_reg, bypass_reg,
                                 flash_ready_busy_n_in, refused_reg,
                                 tmo_reg, done_reg, state_reg != S_IDLE};
          REG_CFG:    rd_reg <= {31'h0000_0000, word_reg};
          default:    rd_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software-written operands; width is only changed between operations
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      addr_reg  <= 20'h0_0000;
      wdata_reg <= 16'h0000;
      word_reg  <= CFG_WORD_RST;
    end else if (avs_write_in && acc_reg) begin
      if (avs_address_in == REG_ADDR)  addr_reg  <= avs_writedata_in[19:0];
      if (avs_address_in == REG_WDATA) wdata_reg <= avs_writedata_in[15:0];
      if (avs_address_in == REG_CFG && state_reg == S_IDLE) begin
        word_reg <= avs_writedata_in[CFG_WORD];
      end
    end
  end

  assign flash_byte_n_out = word_reg;
  assign ua1 = word_reg ? UA1_WORD : UA1_BYTE;
  assign ua2 = word_reg ? UA2_WORD : UA2_BYTE;
  assign cyc.req       = state_reg == S_ISSUE;
  assign cyc.word_mode = word_reg;

  // Command sequence table; OP_RAW_WR composes one plain write of WDATA to ADDR
  always_comb begin
    cyc.wr    = 1'b1;
    cyc.addr  = addr_reg;
    cyc.wdata = wdata_reg;
    st_last   = 1'b1;
    case (op_reg)
      OP_READ: cyc.wr = 1'b0;
      OP_PROGRAM, OP_BYP_ENT: begin
        st_last = step_reg == (op_reg == OP_PROGRAM ? 3'd3 : 3'd2);
        case (step_reg)
          3'd0: {cyc.addr, cyc.wdata} = {ua1, CMD_UNLK1};
          3'd1: {cyc.addr, cyc.wdata} = {ua2, CMD_UNLK2};
          3'd2: {cyc.addr, cyc.wdata} =
                {ua1, op_reg == OP_PROGRAM ? CMD_PROG : CMD_BYPASS};
          default: cyc.wdata = wdata_reg;
        endcase
      end
      OP_BYP_PROG: begin
        st_last = step_reg == 3'd1;
        if (step_reg == 3'd0) cyc.wdata = CMD_PROG;
      end
      OP_BYP_EXIT: begin
        st_last   = step_reg == 3'd1;
        cyc.wdata = step_reg == 3'd0 ? CMD_BYP_X1 : CMD_BYP_X2;
      end
      OP_SEC_ERA, OP_CHIP_ERA: begin
        st_last = step_reg == 3'd5;
        case (step_reg)
          3'd0, 3'd3: {cyc.addr, cyc.wdata} = {ua1, CMD_UNLK1};
          3'd1, 3'd4: {cyc.addr, cyc.wdata} = {ua2, CMD_UNLK2};
          3'd2: {cyc.addr, cyc.wdata} = {ua1, CMD_ERA_SET};
          default: begin
            if (op_reg == OP_CHIP_ERA) begin
              {cyc.addr, cyc.wdata} = {ua1, CMD_ERA_CHP};
            end else begin
              cyc.wdata = CMD_ERA_SEC;
            end
          end
        endcase
      end
      OP_SUSPEND: cyc.wdata = CMD_SUSPEND;
      OP_RESUME:  cyc.wdata = CMD_RESUME;
      default:    cyc.wdata = wdata_reg;
    endcase
  end

  // Sequencer: issue writes, then wait on ready/busy with a timeout
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_reg         <= S_IDLE;
      op_reg            <= OP_READ;
      step_reg          <= 3'd0;
      cnt_reg           <= 32'h0000_0000;
      flash_reset_n_out <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
      case (state_reg)
        S_IDLE: begin
          step_reg <= 3'd0;
          cnt_reg  <= 32'h0000_0000;
          if (start && !refuse) begin
            op_reg    <= new_op;
            state_reg <= new_op == OP_HW_RESET ? S_RSTLO : S_ISSUE;
          end
        end
        S_ISSUE: state_reg <= S_WAIT;
        S_WAIT: begin
          cnt_reg <= 32'h0000_0000;
          if (cyc.done) begin
            step_reg  <= step_reg + 3'd1;
            state_reg <= !st_last ? S_ISSUE : needs_busy ? S_BDLY : S_IDLE;
          end
        end
        // Ready/busy falls only after a delay; sampling early would pass
        S_BDLY: begin
          if (cnt_reg == 32'(TBUSY_CYC - 1)) begin
            state_reg <= S_BUSY;
            cnt_reg   <= 32'h0000_0000;
          end
        end
        S_BUSY: begin
          if (flash_ready_busy_n_in ||
              cnt_reg == 32'(TIMEOUT_CYC - 1)) begin
            state_reg <= S_IDLE;
          end
        end
        S_RSTLO: begin
          flash_reset_n_out <= 1'b0;
          if (cnt_reg == 32'(TRP_CYC)) begin // Pin falls one edge late
            state_reg         <= S_RSTHI;
            cnt_reg           <= 32'h0000_0000;
            flash_reset_n_out <= 1'b1;
          end
        end
        S_RSTHI: if (cnt_reg == 32'(TRH_CYC - 1)) state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Result flags; cleared when an operation is accepted
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      done_reg    <= 1'b0;
      tmo_reg     <= 1'b0;
      refused_reg <= 1'b0;
      rdata_reg   <= 16'h0000;
    end else begin
      if (start) begin
        refused_reg <= refuse;
        if (!refuse) begin
          done_reg <= 1'b0;
          tmo_reg  <= 1'b0;
        end
      end
      if (state_reg == S_WAIT && cyc.done && st_last && !needs_busy) begin
        done_reg <= 1'b1;
        if (op_reg == OP_READ) rdata_reg <= cyc.rdata;
      end
      if (state_reg == S_BUSY && flash_ready_busy_n_in) done_reg <= 1'b1;
      if (state_reg == S_BUSY && !flash_ready_busy_n_in &&
          cnt_reg == 32'(TIMEOUT_CYC - 1)) begin
        done_reg <= 1'b1;
        tmo_reg  <= 1'b1;
      end
      if (state_reg == S_RSTHI && cnt_reg == 32'(TRH_CYC - 1)) begin
        done_reg <= 1'b1;
      end
    end
  end

  // Mode tracking mirrors the flash; reset returns it to array read
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      bypass_reg <= 1'b0;
      susp_reg   <= 1'b0;
    end else if (state_reg == S_RSTLO) begin
      bypass_reg <= 1'b0;
      susp_reg   <= 1'b0;
    end else if (state_reg == S_WAIT && cyc.done && st_last) begin
      if (op_reg == OP_BYP_ENT)  bypass_reg <= 1'b1;
      if (op_reg == OP_BYP_EXIT) bypass_reg <= 1'b0;
      if (op_reg == OP_SUSPEND)  susp_reg   <= 1'b1;
      if (op_reg == OP_RESUME)   susp_reg   <= 1'b0;
    end
  end

  pnfi_cycle u_cycle (
    .clk_sys_in        (clk_sys_in),
    .rst_n_in          (rst_n_in),
    .cyc               (cyc),
    .flash_dq_in       (flash_dq_in),
    .flash_addr_out    (flash_addr_out),
    .flash_dq_out      (flash_dq_out),
    .flash_dq_oe_n_out (flash_dq_oe_n_out),
    .flash_ce_n_out    (flash_ce_n_out),
    .flash_oe_n_out    (flash_oe_n_out),
    .flash_we_n_out    (flash_we_n_out)
  );

endmodule : pnfi_top
